/* File: tsr_regfile.sv */
// tsr_regfile: register file of the three-channel temperature monitor.
// holds the address pointer, result registers and both configuration registers,
// formats converter results, gates pin 13 and registers the overheat pin as requested.
// assumes: a serial front end that delivers written bytes and read requests one
// per cycle, a converter that hands over one result per cycle, and limit logic
// outside that raises the raw alarm and overheat requests.

`timescale 1ns/1ps
`default_nettype none

module tsr_regfile (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register access from the serial front end
  input wire tsr_pkg::tsr_wr_t busWr,
  input wire logic busRdReq,
  output logic [7:0] busRdData,
  output logic busRdValid,
  // converter
  input wire tsr_pkg::tsr_conv_t conv,
  output logic conversionHalt,
  // raw alarm requests from the limit logic
  input wire logic limitAlarmLocal,
  input wire logic limitAlarmRemoteA,
  input wire logic limitAlarmRemoteB,
  input wire logic overheatReq,
  input wire logic secondaryOverheatReq,
  // pins, active high here; the pad inverts
  output logic overheatOut,
  output logic pin13Out,
  // configuration view
  output logic pin13RoleSelect,
  output logic rangeExtended,
  output logic lockActive
);
  import tsr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] ptrQ;
  logic [7:0] ptrD;
  logic [7:0] localQ;
  logic [7:0] cfg1Q;
  logic [7:0] cfg1D;
  logic [7:0] cfg2Q;
  logic [7:0] cfg2D;
  // the pointer, result and configuration registers and the read path are one byte wide
  logic [7:0] rdDataQ;
  logic rdValidQ;
  logic overheatQ;
  logic pin13Q;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  wire logic alarmMask = cfg1Q[CFG1_ALARM_MASK];
  wire logic haltConv = cfg1Q[CFG1_HALT];
  wire logic pin13Role = cfg1Q[CFG1_PIN13];
  wire logic aliasB = cfg1Q[CFG1_ALIAS];
  wire logic extRange = cfg1Q[CFG1_RANGE];
  wire logic blockA = cfg1Q[CFG1_BLOCK_A];
  wire logic blockB = cfg1Q[CFG1_BLOCK_B];
  wire logic locked = cfg2Q[CFG2_LOCK];

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire logic ptrWr = busWr.valid && busWr.first;
  wire logic dataWr = busWr.valid && !busWr.first;
  wire logic cfg1Wr = dataWr && (ptrQ == ADDR_CFG1_WR);
  wire logic cfg2Wr = dataWr && (ptrQ == ADDR_CFG2) && !locked;
  wire logic [7:0] cfg1WrData = busWr.data & ~CFG1_RSVD_MASK;

  // once locked only the alias bit still follows writes
  wire logic [7:0] cfg1Locked = (cfg1Q & ~CFG1_ALIAS_MASK) | (cfg1WrData & CFG1_ALIAS_MASK);

  assign ptrD = ptrWr ? busWr.data : ptrQ;
  // a range change touches config one only; limit values outside keep their contents
  assign cfg1D = cfg1Wr ? (locked ? cfg1Locked : cfg1WrData) : cfg1Q;
  // reserved bits read zero; writes can only set the lock bit, and only reset clears it
  assign cfg2D = cfg2Wr ? {busWr.data[CFG2_LOCK], 7'h00} : cfg2Q;

  // ----------------------------------------------------------------
  // result formatting
  // ----------------------------------------------------------------
  logic [7:0] fmtCode;
  logic fmtSat;

  // the current range bit is applied at capture, so a change shows on the next result
  tsr_temp_fmt #(
    .TEMP_W(TEMP_W)
  ) u_fmt (
    .tempIn(conv.temp),
    .extRange(extRange),
    .code(fmtCode),
    .saturated(fmtSat)
  );

  // a clamped result carries no meaningful fraction
  wire logic [7:0] fracByte = fmtSat ? 8'h00 : {conv.frac, 6'h00};

  // standby drops any result still arriving from the converter
  wire logic take = conv.valid && !haltConv;
  wire logic loadLocal = take && (conv.chan == CH_LOCAL);

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  wire logic selRaHigh = (ptrQ == ADDR_RA_HIGH);
  wire logic selRaLow = (ptrQ == ADDR_RA_LOW);
  wire logic selRbHigh = (ptrQ == ADDR_RB_HIGH);
  wire logic selRbLow = (ptrQ == ADDR_RB_LOW);

  logic [1:0] remLoad;
  logic [1:0] remLowRd;
  logic [1:0] remHighRd;
  logic [7:0] remHi [2];
  logic [7:0] remLo [2];
  logic [7:0] remView [2];

  // alias redirects the remote A addresses, including the low-byte hold
  assign remLowRd[0] = busRdReq && selRaLow && !aliasB;
  assign remLowRd[1] = busRdReq && ((selRaLow && aliasB) || selRbLow);
  assign remHighRd[0] = busRdReq && selRaHigh && !aliasB;
  assign remHighRd[1] = busRdReq && ((selRaHigh && aliasB) || selRbHigh);
  assign remLoad[0] = take && (conv.chan == CH_REMOTE_A);
  assign remLoad[1] = take && (conv.chan == CH_REMOTE_B);

  // ----------------------------------------------------------------
  // remote channels
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_remote
    tsr_remote_chan u_chan (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .load(remLoad[ch]),
      .hiIn(fmtCode),
      .loIn(fracByte),
      .lowRead(remLowRd[ch]),
      .highRead(remHighRd[ch]),
      .hiQ(remHi[ch]),
      .loQ(remLo[ch]),
      .hiView(remView[ch])
    );
  end

  // unmapped and write-only addresses read zero here
  wire logic [7:0] rdMux =
    (ptrQ == ADDR_LOCAL) ? localQ :
    selRaHigh ? (aliasB ? remView[1] : remView[0]) :
    selRaLow ? (aliasB ? remLo[1] : remLo[0]) :
    selRbHigh ? remView[1] :
    selRbLow ? remLo[1] :
    (ptrQ == ADDR_CFG1_RD) ? cfg1Q :
    (ptrQ == ADDR_CFG2) ? cfg2Q :
    8'h00;

  // ----------------------------------------------------------------
  // alarm pins
  // ----------------------------------------------------------------
  // limit-written changes arrive as new raw requests, so standby still updates the pins
  wire logic limitHit = limitAlarmLocal || (limitAlarmRemoteA && !blockA) ||
    (limitAlarmRemoteB && !blockB);
  wire logic alarmPin = !alarmMask && limitHit;
  wire logic pin13Next = pin13Role ? secondaryOverheatReq : alarmPin;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ptrQ <= PTR_RST;
      cfg1Q <= CFG1_RST;
      cfg2Q <= CFG2_RST;
    end
    else
    begin
      ptrQ <= ptrD;
      cfg1Q <= cfg1D;
      cfg2Q <= cfg2D;
    end
  end

  // host writes never reach the result registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      localQ <= TEMP_RST;
    end
    else if (loadLocal)
    begin
      localQ <= fmtCode;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rdDataQ <= 8'h00;
      rdValidQ <= 1'b0;
    end
    else
    begin
      rdValidQ <= busRdReq;
      if (busRdReq)
      begin
        rdDataQ <= rdMux;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      overheatQ <= 1'b0;
      pin13Q <= 1'b0;
    end
    else
    begin
      overheatQ <= overheatReq;
      pin13Q <= pin13Next;
    end
  end

  assign busRdData = rdDataQ;
  assign busRdValid = rdValidQ;
  assign overheatOut = overheatQ;
  assign pin13Out = pin13Q;
  assign conversionHalt = cfg1Q[CFG1_HALT];
  assign pin13RoleSelect = cfg1Q[CFG1_PIN13];
  assign rangeExtended = cfg1Q[CFG1_RANGE];
  assign lockActive = cfg2Q[CFG2_LOCK];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_ptr_byte(logic [7:0] addr);
    busWr.valid && busWr.first && busWr.data == addr;
  endsequence

  // the host may idle between the pointer byte and the data byte
  sequence s_cfg_write(logic [7:0] addr);
    s_ptr_byte(addr) ##[1:4] busWr.valid && !busWr.first && ptrQ == addr;
  endsequence

  a_ptr_load: assert property (busWr.valid && busWr.first |=> ptrQ == $past(busWr.data))
    else $error("pointer did not load first written byte");

  a_rd_answer: assert property (busRdReq && ptrQ == ADDR_CFG1_RD |=> busRdValid && busRdData == $past(cfg1Q))
    else $error("config read did not answer next cycle");

  a_rd_local: assert property (busRdReq && ptrQ == ADDR_LOCAL |=> busRdData == $past(localQ))
    else $error("local read returned wrong data");

  a_alias_low: assert property (busRdReq && selRaLow && aliasB |=> busRdData == $past(remLo[1]))
    else $error("aliased low byte not from remote B");

  a_ro_local: assert property (dataWr && ptrQ == ADDR_LOCAL && !loadLocal |=> $stable(localQ))
    else $error("host write changed a result register");

  a_plain_clamp: assert property (loadLocal && !extRange && conv.temp < 0 |=> localQ == 8'h00)
    else $error("negative plain result not clamped to zero");

  a_plain_top: assert property (loadLocal && !extRange && conv.temp > 127 |=> localQ == PLAIN_MAX)
    else $error("high plain result not clamped");

  a_ext_offset: assert property (loadLocal && extRange && conv.temp >= -64 && conv.temp <= 191
    |=> localQ == 8'($past(conv.temp) + 64))
    else $error("extended result not offset by 64");

  a_halt_hold: assert property (haltConv && conv.valid |=> $stable(localQ))
    else $error("result captured during standby");

  a_mask_all: assert property (alarmMask && !pin13Role |=> !pin13Out)
    else $error("masked alarm reached pin 13");

  a_pin13_role: assert property (pin13Role |=> pin13Out == $past(secondaryOverheatReq))
    else $error("pin 13 not following second overheat");

  a_lock_freeze: assert property (locked ##0 s_cfg_write(ADDR_CFG1_WR)
    |=> (cfg1Q & ~CFG1_ALIAS_MASK) == $past(cfg1Q & ~CFG1_ALIAS_MASK)
      && cfg1Q[CFG1_ALIAS] == $past(busWr.data[CFG1_ALIAS]))
    else $error("locked config changed or alias bit ignored");

  a_lock_sticky: assert property (locked |=> locked)
    else $error("lock bit cleared");

  a_cfg1_write: assert property (s_cfg_write(ADDR_CFG1_WR) ##0 !locked
    |=> cfg1Q == ($past(busWr.data) & ~CFG1_RSVD_MASK))
    else $error("config one write not stored");

  a_rd_valid: assert property (busRdValid == $past(busRdReq))
    else $error("read answer not one cycle after request");

  a_alias_high: assert property (busRdReq && selRaHigh && aliasB |=> busRdData == $past(remView[1]))
    else $error("aliased high byte not from remote B");

  a_ro_remote: assert property (dataWr && ptrQ == ADDR_RB_HIGH && !remLoad[1] |=> $stable(remHi[1]))
    else $error("host write changed a remote result");

  a_block_remote: assert property (!pin13Role && !limitAlarmLocal && (blockA || !limitAlarmRemoteA)
    && (blockB || !limitAlarmRemoteB) |=> !pin13Out)
    else $error("blocked remote alarm reached pin 13");

  a_overheat_pin: assert property (overheatOut == $past(overheatReq))
    else $error("overheat pin not following its request");

endmodule

`default_nettype wire

/* File: tsr_pkg.sv */
// tsr_pkg: register map, field positions, reset values and carrier types
// for the temperature monitor register file.
// assumes: one 8-bit register space reached through a byte stream front end.

package tsr_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LOCAL = 8'h00;
  localparam logic [7:0] ADDR_RA_HIGH = 8'h01;
  localparam logic [7:0] ADDR_CFG1_RD = 8'h03;
  localparam logic [7:0] ADDR_CFG1_WR = 8'h09;
  localparam logic [7:0] ADDR_RA_LOW = 8'h10;
  localparam logic [7:0] ADDR_CFG2 = 8'h24;
  localparam logic [7:0] ADDR_RB_HIGH = 8'h30;
  localparam logic [7:0] ADDR_RB_LOW = 8'h33;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG1_ALARM_MASK = 7;
  localparam int CFG1_HALT = 6;
  localparam int CFG1_PIN13 = 5;
  localparam int CFG1_RSVD = 4;
  localparam int CFG1_ALIAS = 3;
  localparam int CFG1_RANGE = 2;
  localparam int CFG1_BLOCK_A = 1;
  localparam int CFG1_BLOCK_B = 0;
  localparam int CFG2_LOCK = 7;
  localparam int FRAC_POS = 6;

  localparam logic [7:0] CFG1_ALIAS_MASK = 8'h01 << CFG1_ALIAS;
  localparam logic [7:0] CFG1_RSVD_MASK = 8'h01 << CFG1_RSVD;

  // ----------------------------------------------------------------
  // reset values and format constants
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] EXT_OFFSET = 8'h40;
  localparam logic [7:0] PLAIN_MAX = 8'h7F;
  localparam logic [7:0] EXT_MAX = 8'hFF;
  localparam int TEMP_W = 9;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    CH_LOCAL = 2'b00,
    CH_REMOTE_A = 2'b01,
    CH_REMOTE_B = 2'b10,
    CH_NONE = 2'b11
  } tsr_chan_t;

  typedef struct packed
  {
    logic valid;
    tsr_chan_t chan;
    logic signed [TEMP_W-1:0] temp;
    logic [1:0] frac;
  } tsr_conv_t;

  typedef struct packed
  {
    logic valid;
    logic first;
    logic [7:0] data;
  } tsr_wr_t;

endpackage

/* File: tsr_temp_fmt.sv */
// tsr_temp_fmt: turns a signed whole-degree result into the stored byte.
// assumes: result is signed two's complement, TEMP_W bits, purely combinational use.

`timescale 1ns/1ps
`default_nettype none

module tsr_temp_fmt #(
  parameter int TEMP_W = tsr_pkg::TEMP_W
) (
  // input
  input wire logic signed [TEMP_W-1:0] tempIn,
  input wire logic extRange,
  // output
  output logic [7:0] code,
  output logic saturated
);
  import tsr_pkg::*;

  if (TEMP_W < 9)
  begin : g_bad_width
    $error("tsr_temp_fmt: TEMP_W must be at least 9");
  end

  logic signed [TEMP_W:0] widened;
  logic signed [TEMP_W:0] shifted;
  logic [7:0] upper;
  logic belowZero;
  logic aboveMax;

  // extended range adds the offset before clamping to the byte
  assign widened = {tempIn[TEMP_W-1], tempIn};
  assign shifted = extRange ? widened + $signed({{(TEMP_W-7){1'b0}}, EXT_OFFSET}) : widened;
  assign upper = extRange ? EXT_MAX : PLAIN_MAX;
  assign belowZero = shifted[TEMP_W];
  assign aboveMax = !belowZero && (shifted[TEMP_W-1:0] > {{(TEMP_W-8){1'b0}}, upper});
  assign saturated = belowZero || aboveMax;
  assign code = belowZero ? 8'h00 : (aboveMax ? upper : shifted[7:0]);

endmodule

`default_nettype wire

/* File: tsr_remote_chan.sv */
// tsr_remote_chan: high and low result bytes of one remote channel,
// with the high byte snapshot taken by a low-byte read.
// assumes: at most one register read per cycle.

`timescale 1ns/1ps
`default_nettype none

module tsr_remote_chan (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // converter side
  input wire logic load,
  input wire logic [7:0] hiIn,
  input wire logic [7:0] loIn,
  // read side
  input wire logic lowRead,
  input wire logic highRead,
  output logic [7:0] hiQ,
  output logic [7:0] loQ,
  output logic [7:0] hiView
);
  import tsr_pkg::*;

  logic [7:0] snapQ;
  logic heldQ;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      hiQ <= TEMP_RST;
      loQ <= TEMP_RST;
      snapQ <= TEMP_RST;
      heldQ <= 1'b0;
    end
    else
    begin
      if (load)
      begin
        hiQ <= hiIn;
        loQ <= loIn;
      end
      if (lowRead)
      begin
        snapQ <= hiQ;
      end
      heldQ <= lowRead || (heldQ && !highRead);
    end
  end

  // the pair stays coherent even if a fresh result lands between the reads
  assign hiView = heldQ ? snapQ : hiQ;

  sequence s_low_read;
    lowRead;
  endsequence

  sequence s_high_read;
    highRead;
  endsequence

  a_snap_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_low_read |=> (hiView == $past(hiQ)) && heldQ)
    else $error("high byte not held after low-byte read");

  a_snap_release: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_high_read ##0 !lowRead |=> !heldQ && hiView == hiQ)
    else $error("high byte hold not released by high-byte read");

  a_low_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    load |=> loQ[FRAC_POS-1:0] == 6'h00)
    else $error("unused low-byte bits not zero");

endmodule

`default_nettype wire

/* File: tsr_host_model.sv */
// tsr_host_model: stand-in for the serial host, sends pointer and data bytes and read requests.
// assumes: the register file takes at most one byte or one read request per clk_sys edge.

`timescale 1ns/1ps
`default_nettype none

module tsr_host_model (
  // clock
  input wire logic clk_sys,
  // register access
  output var tsr_pkg::tsr_wr_t busWr,
  output logic busRdReq
);
  import tsr_pkg::*;

  // idle cycles before each byte or read, so the host can answer slowly
  int gap = 0;

  initial
  begin
    busWr = '0;
    busRdReq = 1'b0;
  end

  // ----------------------------------------------------------------
  // byte lane
  // ----------------------------------------------------------------
  // a released lane shows the inverse, so stale data never passes for a fresh byte
  task automatic sendByte(input logic isFirst, input logic [7:0] b);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    busWr <= '{valid: 1'b1, first: isFirst, data: b};
    @(posedge clk_sys);
    busWr <= '{valid: 1'b0, first: ~isFirst, data: ~b};
  endtask

  task automatic writeAt(input logic [7:0] a, input logic [7:0] d);
    sendByte(1'b1, a);
    sendByte(1'b0, d);
  endtask

  task automatic readNow();
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    busRdReq <= 1'b1;
    @(posedge clk_sys);
    busRdReq <= 1'b0;
  endtask

  // the pointer byte goes out before the read request
  task automatic readAt(input logic [7:0] a);
    sendByte(1'b1, a);
    readNow();
  endtask
endmodule

`default_nettype wire

/* File: tsr_regfile_bench.sv */
// tsr_regfile_bench: self-checking bench for the register file.
// assumes: tsr_host_model drives the byte stream; the bench drives converter and alarm inputs.

`timescale 1ns/1ps
`default_nettype none

module tsr_regfile_bench;
  import tsr_pkg::*;

  logic clk_sys;
  logic resetn;
  tsr_wr_t busWr;
  logic busRdReq;
  logic [7:0] busRdData;
  logic busRdValid;
  tsr_conv_t conv;
  logic conversionHalt;
  logic lL, lA, lB, oh, soh;
  logic overheatOut, pin13Out, pin13RoleSelect, rangeExtended, lockActive;
  int fails = 0;
  int nCompared = 0;
  logic [7:0] q[$];
  logic [31:0] seed = 32'hFD77;
  logic [31:0] r;
  logic [7:0] cfg1 = 8'h00;
  logic [7:0] cfg2 = 8'h00;
  logic [7:0] hi[3] = '{default: 8'h00};
  logic [7:0] lo[3] = '{default: 8'h00};
  logic [7:0] hd[3] = '{default: 8'h00};
  logic hv[3] = '{default: 1'b0};
  logic [7:0] hiAd[3] = '{ADDR_LOCAL, ADDR_RA_HIGH, ADDR_RB_HIGH};
  logic [7:0] loAd[3] = '{ADDR_LOCAL, ADDR_RA_LOW, ADDR_RB_LOW};
  int temps[7] = '{-55, 0, 1, 25, 75, 127, 150};
  int ch;

  tsr_host_model u_host (.clk_sys(clk_sys), .busWr(busWr), .busRdReq(busRdReq));

  tsr_regfile u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .busWr(busWr), .busRdReq(busRdReq),
    .busRdData(busRdData), .busRdValid(busRdValid), .conv(conv), .conversionHalt(conversionHalt),
    .limitAlarmLocal(lL), .limitAlarmRemoteA(lA), .limitAlarmRemoteB(lB),
    .overheatReq(oh), .secondaryOverheatReq(soh), .overheatOut(overheatOut), .pin13Out(pin13Out),
    .pin13RoleSelect(pin13RoleSelect), .rangeExtended(rangeExtended), .lockActive(lockActive)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && nCompared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [7:0] expRd(input logic [7:0] a, input int c);
    case (a)
      ADDR_LOCAL: return hi[0];
      ADDR_RA_HIGH, ADDR_RB_HIGH: return hv[c] ? hd[c] : hi[c];
      ADDR_RA_LOW, ADDR_RB_LOW: return lo[c];
      ADDR_CFG1_RD: return cfg1;
      ADDR_CFG2: return cfg2;
      default: return 8'h00;
    endcase
  endfunction

  // note the expected byte, track the high-byte snapshot, then read
  task automatic rdChk(input logic [7:0] a);
    int c;
    logic lowRd;
    c = (a == ADDR_RB_HIGH || a == ADDR_RB_LOW || cfg1[CFG1_ALIAS]) ? 2 : 1;
    lowRd = (a == ADDR_RA_LOW || a == ADDR_RB_LOW);
    q.push_back(expRd(a, c));
    if (lowRd)
      hd[c] = hi[c];
    hv[c] = lowRd ? 1'b1 : (a == ADDR_RA_HIGH || a == ADDR_RB_HIGH) ? 1'b0 : hv[c];
    u_host.readAt(a);
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    if (a == ADDR_CFG1_WR)
      cfg1 = cfg2[CFG2_LOCK] ? ((cfg1 & ~CFG1_ALIAS_MASK) | (d & CFG1_ALIAS_MASK)) : (d & ~CFG1_RSVD_MASK);
    if (a == ADDR_CFG2 && !cfg2[CFG2_LOCK])
      cfg2 = d & 8'h80;
    u_host.writeAt(a, d);
    @(negedge clk_sys);
    chk({4'h0, conversionHalt, pin13RoleSelect, rangeExtended, lockActive},
        {4'h0, cfg1[CFG1_HALT], cfg1[CFG1_PIN13], cfg1[CFG1_RANGE], cfg2[CFG2_LOCK]});
  endtask

  task automatic cv(input int c, input int t, input logic [1:0] f);
    int v;
    int mx;
    v = cfg1[CFG1_RANGE] ? t + 64 : t;
    mx = cfg1[CFG1_RANGE] ? 255 : 127;
    if (!cfg1[CFG1_HALT])
      hi[c] = (v < 0) ? 8'h00 : (v > mx) ? mx[7:0] : v[7:0];
    if (!cfg1[CFG1_HALT])
      lo[c] = (v < 0 || v > mx) ? 8'h00 : {f, 6'h00};
    @(posedge clk_sys);
    conv <= '{valid: 1'b1, chan: tsr_chan_t'(c), temp: 9'(t), frac: f};
    @(posedge clk_sys);
    conv <= '{valid: 1'b0, chan: CH_NONE, temp: ~9'(t), frac: ~f};
  endtask

  // ----------------------------------------------------------------
  // read monitor
  // ----------------------------------------------------------------
  always @(negedge clk_sys)
    if (busRdValid === 1'b1)
    begin
      if (q.size() == 0)
        chk(8'hXX, 8'h00);
      else
        chk(busRdData, q.pop_front());
    end

  initial
  begin
    #100000;
    fails++;
    $display("Error at %0t: run did not finish", $time);
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    conv = '0;
    {lL, lA, lB, oh, soh} = 5'h00;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    q.push_back(8'h00);
    u_host.readNow();
    foreach (loAd[i]) rdChk(loAd[i]);
    rdChk(ADDR_RA_HIGH);
    rdChk(ADDR_RB_HIGH);
    rdChk(ADDR_CFG1_WR);
    rdChk(8'h55);
    wrReg(ADDR_CFG1_RD, 8'hFF);
    wrReg(ADDR_LOCAL, 8'hA5);
    wrReg(ADDR_RB_HIGH, 8'h5A);
    rdChk(ADDR_LOCAL);
    rdChk(ADDR_RB_HIGH);
    wrReg(ADDR_CFG1_WR, 8'h14);
    rdChk(ADDR_CFG1_RD);
    foreach (temps[i])
      for (int rg = 0; rg < 2; rg++)
      begin
        wrReg(ADDR_CFG1_WR, rg[0] ? 8'h04 : 8'h00);
        cv(0, temps[i], 2'b00);
        rdChk(ADDR_LOCAL);
      end
    cv(1, 40, 2'b01);
    cv(2, -10, 2'b11);
    foreach (loAd[i]) rdChk(loAd[i]);
    rdChk(ADDR_RA_HIGH);
    rdChk(ADDR_RB_HIGH);
    wrReg(ADDR_CFG1_WR, 8'h08);
    rdChk(ADDR_RA_LOW);
    rdChk(ADDR_RA_HIGH);
    wrReg(ADDR_CFG1_WR, 8'h00);
    rdChk(ADDR_RA_LOW);
    cv(1, 90, 2'b10);
    rdChk(ADDR_RA_HIGH);
    rdChk(ADDR_RA_HIGH);
    rdChk(ADDR_RA_LOW);
    repeat (12)
    begin
      r = rnd();
      ch = int'(r % 3);
      u_host.gap = r[18] ? 2 : 0;
      wrReg(ADDR_CFG1_WR, r[20] ? 8'h04 : 8'h00);
      cv(ch, int'(r[15:8]) - 64, r[17:16]);
      rdChk(loAd[ch]);
      rdChk(hiAd[ch]);
    end
    u_host.gap = 0;
    wrReg(ADDR_CFG1_WR, 8'h40);
    cv(0, 33, 2'b00);
    rdChk(ADDR_LOCAL);
    repeat (16)
    begin
      r = rnd();
      wrReg(ADDR_CFG1_WR, r[7:0] & 8'hE3);
      @(posedge clk_sys);
      {lL, lA, lB, oh, soh} <= r[12:8];
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk({7'h00, pin13Out}, {7'h00, cfg1[CFG1_PIN13] ? soh : !cfg1[CFG1_ALARM_MASK] &
          (lL | lA & !cfg1[CFG1_BLOCK_A] | lB & !cfg1[CFG1_BLOCK_B])});
      chk({7'h00, overheatOut}, {7'h00, oh});
    end
    wrReg(ADDR_CFG1_WR, 8'h04);
    wrReg(ADDR_CFG2, 8'hFF);
    wrReg(ADDR_CFG1_WR, 8'h6B);
    rdChk(ADDR_CFG1_RD);
    wrReg(ADDR_CFG2, 8'h00);
    rdChk(ADDR_CFG2);
    repeat (4) @(posedge clk_sys);
    if (q.size() != 0)
    begin
      fails++;
      $display("Error at %0t: reads left unanswered", $time);
    end
    summarize();
  end
endmodule

`default_nettype wire
